// *** core/igs_defines.vh ***
/*
  constants for the multicast group table: register offsets, field widths, timing.
  assumes a 125 mhz core clock and a simple strobe register port.
*/
`ifndef IGS_DEFINES_VH
`define IGS_DEFINES_VH
// ==========================================================================
// register offsets
`define IGS_REG_CTRL 8'h00
`define IGS_REG_LEAVE_TO 8'h04
`define IGS_REG_STATIC_RTR 8'h08
`define IGS_REG_DYN_RTR 8'h0c
`define IGS_REG_COUNT 8'h10
`define IGS_REG_MBR_TO 8'h14
`define IGS_REG_RTR_TO 8'h18
// ==========================================================================
// control fields
`define IGS_CTRL_BLOCK_UNK 0
// ==========================================================================
// snooped message types
`define IGS_MSG_REPORT_V1 3'h1
`define IGS_MSG_REPORT_V2 3'h2
`define IGS_MSG_REPORT_V3 3'h3
`define IGS_MSG_LEAVE 3'h4
`define IGS_MSG_GEN_QUERY 3'h5
`define IGS_MSG_GRP_QUERY 3'h6
// ==========================================================================
// timing: one ageing tick per millisecond
`define IGS_TICK_NS 1000000
`define IGS_CLK_NS 8
`define IGS_TICK_CYC (`IGS_TICK_NS / `IGS_CLK_NS)
`define IGS_MBR_TO_RST 32'h0003_d090
`define IGS_RTR_TO_RST 32'h0003_d090
`define IGS_LEAVE_TO_RST 32'h0000_03e8
`endif

// *** core/igs_group_table.v ***
/*
  igmp snooping group table: learns groups, member ports and router ports from
  decoded igmp messages and answers destination lookups with an egress mask.
  assumes a parser upstream presents one decoded message per valid pulse and
  a forwarding stage presents one lookup per valid pulse.
*/
// Design decisions made here: the address map and the strobed register port.
// ==========================================================================
`timescale 1ns/10ps
`include "igs_defines.vh"
module igs_group_table #(
  parameter NPORT = 8,
  parameter NGRP = 64,
  parameter TICK_CYC = `IGS_TICK_CYC
) (
  input wire clk, // core clock
  input wire rst_b, // synchronous reset, active low
  input wire msg_valid, // decoded igmp message pulse
  input wire [2:0] msg_type, // message kind
  input wire [27:0] msg_group, // group address low 28 bits
  input wire [NPORT-1:0] msg_port, // one-hot ingress port
  input wire [31:0] msg_max_resp, // query max response, ms
  input wire lk_valid, // multicast lookup pulse
  input wire [27:0] lk_group, // lookup destination group
  input wire [NPORT-1:0] lk_domain, // broadcast domain ports
  input wire [7:0] reg_addr, // register address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, cycle after read
  output reg lk_done, // lookup answer pulse
  output reg [NPORT-1:0] lk_mask, // egress ports
  output reg lk_drop, // frame to be dropped
  output reg msg_done, // message handled pulse
  output reg [NPORT-1:0] msg_fwd_mask, // ports to relay igmp message
  output reg table_full // group table full
);
  // ========================================================================
  // registers and table storage
  localparam PW = NPORT;
  reg block_unk_q; // drop unlearned multicast
  reg [31:0] leave_to_q; // leave timeout, ms
  reg [31:0] mbr_to_q; // membership interval, ms
  reg [31:0] rtr_to_q; // router port interval, ms
  reg [PW-1:0] static_rtr_q; // static router ports
  reg [PW-1:0] dyn_rtr_q; // learned router ports
  reg [31:0] rtr_age_q [0:PW-1]; // per port router ageing
  reg [27:0] grp_addr_q [0:NGRP-1]; // entry group address
  reg grp_vld_q [0:NGRP-1]; // entry valid
  reg [PW-1:0] grp_mask_q [0:NGRP-1]; // entry member ports
  reg [31:0] grp_age_q [0:NGRP-1]; // entry ageing timer, ms
  reg grp_lv_q [0:NGRP-1]; // leave pending
  reg [31:0] tick_cnt_q; // millisecond prescaler
  reg tick_q; // one-cycle millisecond tick
  reg [6:0] count_q; // valid entries
  // ========================================================================
  // match and free search
  reg msg_hit;
  reg [5:0] msg_idx;
  reg free_ok;
  reg [5:0] free_idx;
  reg lk_hit;
  reg [5:0] lk_idx;
  integer i;
  // find message group, first free slot, and lookup group
  always @*
  begin
    msg_hit = 1'b0;
    msg_idx = 6'h00;
    free_ok = 1'b0;
    free_idx = 6'h00;
    lk_hit = 1'b0;
    lk_idx = 6'h00;
    for (i = NGRP-1; i >= 0; i = i - 1)
    begin
      if (grp_vld_q[i] && grp_addr_q[i] == msg_group)
      begin
        msg_hit = 1'b1;
        msg_idx = i[5:0];
      end
      if (!grp_vld_q[i])
      begin
        free_ok = 1'b1;
        free_idx = i[5:0];
      end
      if (grp_vld_q[i] && grp_addr_q[i] == lk_group)
      begin
        lk_hit = 1'b1;
        lk_idx = i[5:0];
      end
    end
  end
  wire is_report = msg_valid && (msg_type == `IGS_MSG_REPORT_V1 || msg_type == `IGS_MSG_REPORT_V2 ||
    msg_type == `IGS_MSG_REPORT_V3);
  wire is_leave = msg_valid && msg_type == `IGS_MSG_LEAVE;
  wire is_query = msg_valid && (msg_type == `IGS_MSG_GEN_QUERY || msg_type == `IGS_MSG_GRP_QUERY);
  wire is_gquery = msg_valid && msg_type == `IGS_MSG_GRP_QUERY;
  // ========================================================================
  // millisecond tick
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == TICK_CYC - 1)
    begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
  // ========================================================================
  // register writes
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      block_unk_q <= 1'b0;
      leave_to_q <= `IGS_LEAVE_TO_RST;
      mbr_to_q <= `IGS_MBR_TO_RST;
      rtr_to_q <= `IGS_RTR_TO_RST;
      static_rtr_q <= {PW{1'b0}};
    end
    else if (reg_wr)
    begin
      if (reg_addr == `IGS_REG_CTRL)
        block_unk_q <= reg_wdata[`IGS_CTRL_BLOCK_UNK];
      else if (reg_addr == `IGS_REG_LEAVE_TO)
        leave_to_q <= reg_wdata;
      else if (reg_addr == `IGS_REG_STATIC_RTR)
        static_rtr_q <= reg_wdata[PW-1:0];
      else if (reg_addr == `IGS_REG_MBR_TO)
        mbr_to_q <= reg_wdata;
      else if (reg_addr == `IGS_REG_RTR_TO)
        rtr_to_q <= reg_wdata;
    end
  end
  // register reads, data the cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      if (reg_addr == `IGS_REG_CTRL)
        reg_rdata <= {31'h0, block_unk_q};
      else if (reg_addr == `IGS_REG_LEAVE_TO)
        reg_rdata <= leave_to_q;
      else if (reg_addr == `IGS_REG_STATIC_RTR)
        reg_rdata <= {{(32-PW){1'b0}}, static_rtr_q};
      else if (reg_addr == `IGS_REG_DYN_RTR)
        reg_rdata <= {{(32-PW){1'b0}}, dyn_rtr_q};
      else if (reg_addr == `IGS_REG_COUNT)
        reg_rdata <= {25'h0, count_q};
      else if (reg_addr == `IGS_REG_MBR_TO)
        reg_rdata <= mbr_to_q;
      else if (reg_addr == `IGS_REG_RTR_TO)
        reg_rdata <= rtr_to_q;
      else
        reg_rdata <= 32'h0; // unmapped reads zero
    end
    else
      reg_rdata <= 32'h0;
  end
  // ========================================================================
  // router ports: learned from queries, aged per port
  genvar p;
  generate
    for (p = 0; p < PW; p = p + 1)
    begin : g_rtr
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          dyn_rtr_q[p] <= 1'b0;
          rtr_age_q[p] <= 32'h0;
        end
        else if (is_query && msg_port[p])
        begin
          dyn_rtr_q[p] <= 1'b1;
          rtr_age_q[p] <= rtr_to_q;
        end
        else if (tick_q && dyn_rtr_q[p])
        begin
          if (rtr_age_q[p] <= 32'h1)
            dyn_rtr_q[p] <= 1'b0;
          rtr_age_q[p] <= rtr_age_q[p] - 32'h1;
        end
      end
    end
  endgenerate
  // ========================================================================
  // group entries: learn, refresh, leave and age
  genvar g;
  generate
    for (g = 0; g < NGRP; g = g + 1)
    begin : g_ent
      wire sel_hit = msg_hit && msg_idx == g;
      wire sel_new = !msg_hit && free_ok && free_idx == g;
      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          grp_vld_q[g] <= 1'b0;
          grp_addr_q[g] <= 28'h0;
          grp_mask_q[g] <= {PW{1'b0}};
          grp_age_q[g] <= 32'h0;
          grp_lv_q[g] <= 1'b0;
        end
        else if (is_report && (sel_hit || sel_new))
        begin
          grp_vld_q[g] <= 1'b1;
          grp_addr_q[g] <= msg_group;
          grp_mask_q[g] <= (sel_hit ? grp_mask_q[g] : {PW{1'b0}}) | msg_port;
          grp_age_q[g] <= mbr_to_q;
          grp_lv_q[g] <= 1'b0;
        end
        else if (is_leave && sel_hit)
        begin
          if (leave_to_q == 32'h0)
            grp_vld_q[g] <= 1'b0;
          else
          begin
            grp_lv_q[g] <= 1'b1;
            if (leave_to_q < grp_age_q[g])
              grp_age_q[g] <= leave_to_q;
          end
        end
        else if (is_gquery && sel_hit && grp_lv_q[g] && msg_max_resp < grp_age_q[g])
          grp_age_q[g] <= (msg_max_resp == 32'h0) ? 32'h1 : msg_max_resp;
        else if (tick_q && grp_vld_q[g])
        begin
          if (grp_age_q[g] <= 32'h1)
            grp_vld_q[g] <= 1'b0;
          grp_age_q[g] <= grp_age_q[g] - 32'h1;
        end
      end
    end
  endgenerate
  // ========================================================================
  // occupancy count
  integer c;
  reg [6:0] cnt_d;
  always @*
  begin
    cnt_d = 7'h0;
    for (c = 0; c < NGRP; c = c + 1)
      cnt_d = cnt_d + {6'h0, grp_vld_q[c]};
  end
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      count_q <= 7'h0;
      table_full <= 1'b0;
    end
    else
    begin
      count_q <= cnt_d;
      table_full <= (cnt_d == NGRP);
    end
  end
  // ========================================================================
  // lookup answer and igmp relay mask
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      lk_done <= 1'b0;
      lk_mask <= {PW{1'b0}};
      lk_drop <= 1'b0;
      msg_done <= 1'b0;
      msg_fwd_mask <= {PW{1'b0}};
    end
    else
    begin
      lk_done <= lk_valid;
      msg_done <= msg_valid;
      if (lk_valid)
      begin
        if (lk_hit)
        begin
          lk_mask <= grp_mask_q[lk_idx] & lk_domain;
          lk_drop <= 1'b0;
        end
        else if (block_unk_q)
        begin
          lk_mask <= {PW{1'b0}};
          lk_drop <= 1'b1;
        end
        else
        begin
          lk_mask <= lk_domain;
          lk_drop <= 1'b0;
        end
      end
      if (msg_valid)
      begin
        if (is_report || is_leave)
          msg_fwd_mask <= (static_rtr_q | dyn_rtr_q) & ~msg_port;
        else
          msg_fwd_mask <= lk_domain & ~msg_port;
      end
    end
  end
endmodule

// *** verification/igs_group_table_chk.sv ***
/* checker: handshake and mask relations of the group table.
   assumes a bind onto igs_group_table. */
`timescale 1ns/10ps
`include "igs_defines.vh"
module igs_chk #(
  parameter NPORT = 8
) (
  input wire clk, // core clock
  input wire rst_b, // sync reset, low
  input wire msg_valid, // message pulse
  input wire [2:0] msg_type, // message kind
  input wire [NPORT-1:0] msg_port, // ingress port
  input wire lk_valid, // lookup pulse
  input wire [NPORT-1:0] lk_domain, // domain ports
  input wire reg_rd, // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire lk_done, // lookup answer
  input wire [NPORT-1:0] lk_mask, // egress ports
  input wire lk_drop, // drop flag
  input wire msg_done, // message answer
  input wire [NPORT-1:0] msg_fwd_mask // relay ports
);
  // ==========================================
  // answers follow requests by one cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_lk_ans;
    ##1 lk_done;
  endsequence
  sequence s_msg_ans;
    ##1 msg_done;
  endsequence
  a_lk_answer: assert property (lk_valid |-> s_lk_ans)
    else $error("lookup not answered");
  a_lk_cause: assert property (lk_done |-> $past(lk_valid))
    else $error("lookup answer without request");
  a_msg_answer: assert property (msg_valid |-> s_msg_ans)
    else $error("message not answered");
  a_msg_cause: assert property (msg_done |-> $past(msg_valid))
    else $error("message answer without request");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  a_mask_stand: assert property (!lk_valid |=> $stable(lk_mask) && $stable(lk_drop))
    else $error("lookup result moved");
  a_mask_domain: assert property (lk_valid |=> (lk_mask & ~$past(lk_domain)) == '0)
    else $error("egress outside domain");
  a_relay_ingress: assert property (msg_valid |=> (msg_fwd_mask & $past(msg_port)) == '0)
    else $error("message relayed to ingress");
  a_query_relay: assert property (msg_valid && (msg_type == `IGS_MSG_GEN_QUERY ||
    msg_type == `IGS_MSG_GRP_QUERY) |=> msg_fwd_mask == ($past(lk_domain) & ~$past(msg_port)))
    else $error("query relay mask wrong");
endmodule
bind igs_group_table igs_chk #(.NPORT(NPORT)) u_chk (.clk(clk), .rst_b(rst_b), .msg_valid(msg_valid),
  .msg_type(msg_type), .msg_port(msg_port), .lk_valid(lk_valid), .lk_domain(lk_domain), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lk_done(lk_done), .lk_mask(lk_mask), .lk_drop(lk_drop), .msg_done(msg_done),
  .msg_fwd_mask(msg_fwd_mask));

// *** verification/igs_host_model.sv ***
/* model of igmp hosts and routers on the switch ports.
   assumes the bench calls send once per message. */
`timescale 1ns/10ps
module igs_host_model (
  input wire clk, // core clock
  output logic msg_valid, // message pulse
  output logic [2:0] msg_type, // message kind
  output logic [27:0] msg_group, // group address
  output logic [7:0] msg_port, // one-hot ingress
  output logic [31:0] msg_max_resp // query response time
);
  // quiet lines at start
  initial
  begin
    msg_valid = 1'b0;
    msg_type = 3'h0;
    msg_group = 28'h0;
    msg_port = 8'h0;
    msg_max_resp = 32'h0;
  end
  // one message pulse, then stale lines are inverted
  task automatic send(input logic [2:0] t, input logic [27:0] g, input logic [7:0] p, input logic [31:0] r);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_type <= t;
    msg_group <= g;
    msg_port <= p;
    msg_max_resp <= r;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_type <= ~t;
    msg_group <= ~g;
    msg_port <= ~p;
    msg_max_resp <= ~r;
  endtask
endmodule

// *** verification/tb_igmp_snooping_group_table.sv ***
/* bench for the group table: host model, register port, lookups.
   assumes igs_defines.vh on the include path. */
`timescale 1ns/10ps
`include "igs_defines.vh"
module tb_igmp_snooping_group_table;
  logic clk, rst_b, lk_valid, reg_wr, reg_rd, rd_pend;
  logic [27:0] lk_group, base;
  logic [7:0] lk_domain, reg_addr, dom;
  logic [31:0] reg_wdata;
  wire msg_valid, lk_done, lk_drop, msg_done, table_full;
  wire [2:0] msg_type;
  wire [27:0] msg_group;
  wire [7:0] msg_port, lk_mask, msg_fwd_mask;
  wire [31:0] msg_max_resp, reg_rdata;
  logic [31:0] rq[$]; // expected read data
  logic [17:0] lq[$]; // expected {care, drop+mask}
  logic [7:0] mq[$]; // expected relay masks
  logic [17:0] t;
  int err_total, checks_done, cyc, i;
  igs_host_model u_peer (.clk(clk), .msg_valid(msg_valid), .msg_type(msg_type), .msg_group(msg_group),
    .msg_port(msg_port), .msg_max_resp(msg_max_resp));
  igs_group_table #(.TICK_CYC(4)) u_dut (.clk(clk), .rst_b(rst_b), .msg_valid(msg_valid),
    .msg_type(msg_type), .msg_group(msg_group), .msg_port(msg_port), .msg_max_resp(msg_max_resp),
    .lk_valid(lk_valid), .lk_group(lk_group), .lk_domain(lk_domain), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lk_done(lk_done),
    .lk_mask(lk_mask), .lk_drop(lk_drop), .msg_done(msg_done), .msg_fwd_mask(msg_fwd_mask),
    .table_full(table_full));
  // 8 ns clock
  always #4 clk = ~clk;
  // ==========================================
  // compare and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      summarize();
    end
  end
  // monitor: oldest note against each answer
  always @(negedge clk)
  begin
    if (rd_pend)
      check(reg_rdata, rq.pop_front());
    rd_pend = reg_rd;
    if (lk_done)
    begin
      t = lq.pop_front();
      check({lk_drop, lk_mask} & t[17:9], t[8:0]);
    end
    if (msg_done)
      check(msg_fwd_mask, mq.pop_front());
  end
  // ==========================================
  // drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic look(input logic [27:0] g, input logic [7:0] d, input logic [8:0] c, input logic [8:0] e);
    lq.push_back({c, e});
    @(posedge clk);
    lk_group <= g;
    lk_domain <= d;
    lk_valid <= 1'b1;
    @(posedge clk);
    lk_valid <= 1'b0;
  endtask
  task automatic msg(input logic [2:0] k, input logic [27:0] g, input logic [7:0] p, input logic [7:0] e);
    mq.push_back(e);
    u_peer.send(k, g, p, 32'h1);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    lk_valid = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_pend = 1'b0;
    lk_group = 28'h0;
    lk_domain = 8'hff;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    i = $urandom(32'hfd7d);
    base = $urandom;
    dom = $urandom;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(`IGS_REG_LEAVE_TO, `IGS_LEAVE_TO_RST);
    rd(`IGS_REG_MBR_TO, `IGS_MBR_TO_RST);
    rd(`IGS_REG_RTR_TO, `IGS_RTR_TO_RST);
    rd(`IGS_REG_CTRL, 32'h0);
    rd(8'hfc, 32'h0);
    look(base + 28'h100, 8'hff, 9'h1ff, 9'h0ff);
    wr(`IGS_REG_CTRL, 32'h1);
    look(base + 28'h100, 8'hff, 9'h1ff, 9'h100);
    wr(`IGS_REG_CTRL, 32'h0);
    msg(`IGS_MSG_GEN_QUERY, 28'h0, 8'h80, 8'h7f);
    rd(`IGS_REG_DYN_RTR, 32'h80);
    wr(`IGS_REG_STATIC_RTR, 32'h40);
    msg(`IGS_MSG_REPORT_V1, base + 28'h101, 8'h01, 8'hc0);
    msg(`IGS_MSG_REPORT_V2, base + 28'h101, 8'h02, 8'hc0);
    msg(`IGS_MSG_REPORT_V3, base + 28'h101, 8'h04, 8'hc0);
    look(base + 28'h101, 8'hff, 9'h1ff, 9'h007);
    look(base + 28'h101, dom, 9'h1ff, {1'b0, dom & 8'h07});
    wr(`IGS_REG_LEAVE_TO, 32'h0);
    msg(`IGS_MSG_REPORT_V2, base + 28'h102, 8'h08, 8'hc0);
    msg(`IGS_MSG_LEAVE, base + 28'h102, 8'h08, 8'hc0);
    look(base + 28'h102, 8'hff, 9'h1ff, 9'h0ff);
    wr(`IGS_REG_LEAVE_TO, 32'h3);
    msg(`IGS_MSG_REPORT_V2, base + 28'h102, 8'h10, 8'hc0);
    msg(`IGS_MSG_LEAVE, base + 28'h102, 8'h10, 8'hc0);
    look(base + 28'h102, 8'hff, 9'h1ff, 9'h010);
    repeat (30) @(posedge clk);
    look(base + 28'h102, 8'hff, 9'h1ff, 9'h0ff);
    wr(`IGS_REG_LEAVE_TO, 32'h3e8);
    msg(`IGS_MSG_REPORT_V2, base + 28'h102, 8'h20, 8'hc0);
    msg(`IGS_MSG_LEAVE, base + 28'h102, 8'h20, 8'hc0);
    msg(`IGS_MSG_GRP_QUERY, base + 28'h102, 8'h80, 8'h7f);
    repeat (30) @(posedge clk);
    look(base + 28'h102, 8'hff, 9'h1ff, 9'h0ff);
    wr(`IGS_REG_RTR_TO, 32'h2);
    msg(`IGS_MSG_GEN_QUERY, 28'h0, 8'h80, 8'h7f);
    wr(`IGS_REG_MBR_TO, 32'h2);
    repeat (30) @(posedge clk);
    rd(`IGS_REG_DYN_RTR, 32'h0);
    rd(`IGS_REG_STATIC_RTR, 32'h40);
    msg(`IGS_MSG_REPORT_V1, base + 28'h101, 8'h01, 8'h40);
    repeat (30) @(posedge clk);
    look(base + 28'h101, 8'hff, 9'h1ff, 9'h0ff);
    rd(`IGS_REG_COUNT, 32'h0);
    wr(`IGS_REG_MBR_TO, `IGS_MBR_TO_RST);
    for (i = 0; i < 64; i++)
      msg(`IGS_MSG_REPORT_V2, base + i, 8'h01, 8'h40);
    rd(`IGS_REG_COUNT, 32'd64);
    repeat (3) @(negedge clk);
    check(table_full, 32'h1);
    msg(`IGS_MSG_REPORT_V2, base + 28'd64, 8'h01, 8'h40);
    look(base + 28'd64, 8'hff, 9'h1ff, 9'h0ff);
    rd(`IGS_REG_COUNT, 32'h40);
    repeat (4) @(posedge clk);
    // every noted expectation must have met its answer
    check(rq.size() + lq.size() + mq.size(), 32'h0);
    summarize();
  end
endmodule
